// ### include/lan_dma_defines.svh
// timing counts, burst sizes and trigger levels for the lan buffer dma
// assumes inclusion by bare name from the design files
`ifndef LAN_DMA_DEFINES_SVH
`define LAN_DMA_DEFINES_SVH
`define BURST_BYTES 8
`define RX_TRIGGER_LEVEL 8
`define TX_TRIGGER_LEVEL 8
`define CLK_PERIOD_NS 100
`define BYTE_TIME_NS 200
`define BYTE_CYCLES ((`BYTE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ### include/lan_dma_pkg.sv
// types shared by the dma controller and its memory interface unit
// assumes nothing beyond a systemverilog compiler
package lan_dma_pkg;
	typedef enum logic [1:0] {dir_none, dir_rx, dir_tx} dir_e;
	typedef enum logic [1:0] {st_idle, st_setup, st_wait, st_next} dma_state_e;
	typedef enum logic [1:0] {mi_idle, mi_slot, mi_strobe} miu_state_e;
endpackage

// ### hw/memory_interface_unit.sv
// memory interface unit: one byte access to buffer ram in two clocks
// assumes slot_ok marks time slots owned by the dma
`include "lan_dma_defines.svh"
module memory_interface_unit (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic write,
	input wire logic slot_ok,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic [7:0] mem_rdata,
	output logic buffer_ram_output_enable,
	output logic buffer_ram_write_strobe,
	output logic [7:0] rdata,
	output logic done
);
	// ------------------------------------------------------------
	// access sequencer
	// ------------------------------------------------------------
	lan_dma_pkg::miu_state_e st_q;
	logic wr_q;
	logic [1:0] cnt_q;

	// waits for the next dma slot, then strobes for one clock less than the byte time
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= lan_dma_pkg::mi_idle;
			wr_q <= 1'b0;
			cnt_q <= 2'h0;
			mem_addr <= 16'h0000;
			mem_wdata <= 8'h00;
			buffer_ram_output_enable <= 1'b0;
			buffer_ram_write_strobe <= 1'b0;
			rdata <= 8'h00;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (st_q)
				lan_dma_pkg::mi_idle: begin
					if (start) begin
						wr_q <= write;
						mem_addr <= addr;
						mem_wdata <= wdata;
						// a start inside a dma slot strobes at once, else waits for one
						if (slot_ok) begin
							st_q <= lan_dma_pkg::mi_strobe;
							cnt_q <= 2'(`BYTE_CYCLES - 1);
							buffer_ram_output_enable <= ~write;
							buffer_ram_write_strobe <= write;
						end else begin
							st_q <= lan_dma_pkg::mi_slot;
						end
					end
				end
				lan_dma_pkg::mi_slot: begin
					if (slot_ok) begin
						st_q <= lan_dma_pkg::mi_strobe;
						cnt_q <= 2'(`BYTE_CYCLES - 1);
						buffer_ram_output_enable <= ~wr_q;
						buffer_ram_write_strobe <= wr_q;
					end
				end
				lan_dma_pkg::mi_strobe: begin
					if (cnt_q == 2'h1) begin
						st_q <= lan_dma_pkg::mi_idle;
						buffer_ram_output_enable <= 1'b0;
						buffer_ram_write_strobe <= 1'b0;
						if (!wr_q)
							rdata <= mem_rdata;
						done <= 1'b1;
					end
					cnt_q <= cnt_q - 2'h1;
				end
				default: st_q <= lan_dma_pkg::mi_idle;
			endcase
		end
	end

	// two clocks per byte: one strobe-set edge, one sample edge
	chk_miu_two_cycles: assert property (@(posedge clk) disable iff (rst)
		$rose(buffer_ram_output_enable | buffer_ram_write_strobe) |-> ##1 done)
		else $error("byte access not two clocks");
	chk_miu_strobe_excl: assert property (@(posedge clk) disable iff (rst)
		!(buffer_ram_output_enable && buffer_ram_write_strobe))
		else $error("both ram strobes active");
endmodule

// ### hw/lan_buffer_dma_controller.sv
// shared byte-wide dma between lan fifos and 16-bit addressed buffer ram
// assumes fifo levels are exact and fifo handshakes complete in one clock
`include "lan_dma_defines.svh"
module lan_buffer_dma_controller #(
	parameter int BURST = `BURST_BYTES,
	parameter int RX_LEVEL = `RX_TRIGGER_LEVEL,
	parameter int TX_LEVEL = `TX_TRIGGER_LEVEL
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wide_bus,
	input wire logic slot_ok,
	input wire logic [4:0] rx_fifo_level,
	input wire logic [7:0] rx_fifo_data,
	output logic rx_fifo_pop,
	input wire logic [4:0] tx_fifo_level,
	output logic [7:0] tx_fifo_data,
	output logic tx_fifo_push,
	input wire logic [15:0] rx_addr,
	input wire logic [15:0] tx_addr,
	input wire logic tx_pending,
	input wire logic reg_access,
	input wire logic reg_write,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	output logic mem_hi_lane,
	output logic buffer_ram_output_enable,
	output logic buffer_ram_write_strobe,
	output logic busy,
	output logic burst_done
);
	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	initial begin
		if (BURST != 8 || BURST % 2 != 0)
			$error("burst must be eight bytes");
		if (RX_LEVEL < 1 || RX_LEVEL > 31 || TX_LEVEL < 0 || TX_LEVEL > 31)
			$error("trigger level out of fifo range");
	end

	localparam logic [4:0] RX_LVL = 5'(RX_LEVEL);
	localparam logic [4:0] TX_LVL = 5'(TX_LEVEL);
	localparam logic [3:0] BURST_N = 4'(BURST);

	// ------------------------------------------------------------
	// request arbitration
	// ------------------------------------------------------------
	lan_dma_pkg::dma_state_e st_q;
	lan_dma_pkg::dir_e dir_q;
	logic [3:0] cnt_q;
	logic [15:0] addr_q;
	logic [7:0] asm_lo_q;
	logic [7:0] out_byte_q;
	logic half_q;
	logic miu_start;
	logic miu_done;
	logic [7:0] miu_rdata;
	logic [15:0] miu_addr;
	logic [7:0] miu_wdata;
	logic rx_req;
	logic tx_req;

	// rx outranks tx: losing receive data is worse than a late tx fill
	assign rx_req = rx_fifo_level >= RX_LVL;
	assign tx_req = tx_pending && (tx_fifo_level <= TX_LVL);
	assign busy = st_q != lan_dma_pkg::st_idle;

	// ------------------------------------------------------------
	// burst sequencer
	// ------------------------------------------------------------
	// one engine for both directions; burst always finishes first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= lan_dma_pkg::st_idle;
			dir_q <= lan_dma_pkg::dir_none;
			cnt_q <= 4'h0;
			addr_q <= 16'h0000;
			half_q <= 1'b0;
			burst_done <= 1'b0;
		end else begin
			burst_done <= 1'b0;
			case (st_q)
				lan_dma_pkg::st_idle: begin
					// one direction at a time; truly concurrent traffic is not served
					if (rx_req) begin
						dir_q <= lan_dma_pkg::dir_rx;
						addr_q <= rx_addr;
						st_q <= lan_dma_pkg::st_setup;
						cnt_q <= BURST_N;
						half_q <= 1'b0;
					end else if (tx_req) begin
						dir_q <= lan_dma_pkg::dir_tx;
						addr_q <= tx_addr;
						st_q <= lan_dma_pkg::st_setup;
						cnt_q <= BURST_N;
						half_q <= 1'b0;
					end
				end
				lan_dma_pkg::st_setup: begin
					// address already loaded; start and the rx pop are issued here
					st_q <= lan_dma_pkg::st_wait;
				end
				lan_dma_pkg::st_wait: begin
					if (miu_done) begin
						cnt_q <= cnt_q - 4'h1;
						addr_q <= addr_q + 16'h0001;
						half_q <= ~half_q;
						// no gap state: three clocks a byte keeps duplex loopback fed
						// dir_q is kept so the finished direction shows with burst_done
						if (cnt_q == 4'h1) begin
							st_q <= lan_dma_pkg::st_idle;
							burst_done <= 1'b1;
						end else begin
							st_q <= lan_dma_pkg::st_setup;
						end
					end
				end
				default: st_q <= lan_dma_pkg::st_idle;
			endcase
		end
	end

	// pop rx byte into latch during setup, in the same cycle as the start
	logic pop_now;
	assign pop_now = (st_q == lan_dma_pkg::st_setup) && (dir_q == lan_dma_pkg::dir_rx);
	assign rx_fifo_pop = pop_now;
	assign miu_start = (st_q == lan_dma_pkg::st_setup);
	assign miu_addr = addr_q;
	assign miu_wdata = rx_fifo_data;

	// ------------------------------------------------------------
	// assembly and disassembly latches
	// ------------------------------------------------------------
	// assembly pairs rx bytes; wide bus sees a word on odd byte
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			asm_lo_q <= 8'h00;
		end else if (pop_now && !half_q) begin
			asm_lo_q <= rx_fifo_data;
		end
	end

	// disassembly: split the read word by lane onto the byte path
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_byte_q <= 8'h00;
			tx_fifo_push <= 1'b0;
		end else begin
			tx_fifo_push <= miu_done && (dir_q == lan_dma_pkg::dir_tx);
			if (miu_done && dir_q == lan_dma_pkg::dir_tx)
				out_byte_q <= miu_rdata;
		end
	end
	assign tx_fifo_data = out_byte_q;

	// register access bypasses both latches entirely
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (reg_access && !reg_write)
			reg_rdata <= reg_wdata;
	end

	// ------------------------------------------------------------
	// external lane steering
	// ------------------------------------------------------------
	logic [7:0] mem_byte_out;
	logic [7:0] lane_rdata;
	logic miu_wr;
	assign miu_wr = dir_q == lan_dma_pkg::dir_rx;
	// odd address takes the high lane of a wide bus
	assign mem_hi_lane = wide_bus & mem_addr[0];
	assign mem_wdata = wide_bus ? {mem_byte_out, asm_lo_q} : {8'h00, mem_byte_out};
	assign lane_rdata = mem_hi_lane ? mem_rdata[15:8] : mem_rdata[7:0];

	memory_interface_unit u_miu (
		.clk(clk),
		.rst(rst),
		.start(miu_start),
		.write(miu_wr),
		.slot_ok(slot_ok),
		.addr(miu_addr),
		.wdata(miu_wdata),
		.mem_addr(mem_addr),
		.mem_wdata(mem_byte_out),
		.mem_rdata(lane_rdata),
		.buffer_ram_output_enable(buffer_ram_output_enable),
		.buffer_ram_write_strobe(buffer_ram_write_strobe),
		.rdata(miu_rdata),
		.done(miu_done)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// bytes moved since the last burst end, for the burst length check
	int unsigned byte_cnt;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			byte_cnt <= 0;
		else if (burst_done)
			byte_cnt <= 0;
		else if (miu_done)
			byte_cnt <= byte_cnt + 1;
	end

	// a burst ends only after exactly eight accesses
	chk_burst_eight_bytes: assert property (@(posedge clk) disable iff (rst)
		burst_done |-> byte_cnt == 8)
		else $error("burst not eight bytes");

	// burst_done is a single pulse, never a level
	chk_done_pulse: assert property (@(posedge clk) disable iff (rst)
		burst_done |=> !burst_done)
		else $error("burst done held high");

	// an rx fifo at or above its trigger level seen while idle always opens an rx burst
	chk_rx_trigger: assert property (@(posedge clk) disable iff (rst)
		(st_q == lan_dma_pkg::st_idle && rx_fifo_level >= RX_LVL)
		|=> dir_q == lan_dma_pkg::dir_rx)
		else $error("rx burst not started");

	// tx only wins the engine when rx is below its trigger level
	chk_tx_trigger: assert property (@(posedge clk) disable iff (rst)
		(st_q == lan_dma_pkg::st_idle && !rx_req && tx_req)
		|=> dir_q == lan_dma_pkg::dir_tx)
		else $error("tx burst not started");

	// direction holds from the first setup until the engine is idle again
	chk_dir_stable: assert property (@(posedge clk) disable iff (rst)
		(st_q != lan_dma_pkg::st_idle && $past(st_q) != lan_dma_pkg::st_idle)
		|-> $stable(dir_q))
		else $error("direction switched mid burst");

	// start only once the address has moved on, after idle or a finished access
	chk_start_setup: assert property (@(posedge clk) disable iff (rst)
		miu_start |-> !$past(miu_start)
		&& ($past(st_q) == lan_dma_pkg::st_idle || $past(miu_done)))
		else $error("start without setup");

	// the rx byte is popped while the ram is still quiet
	chk_pop_quiet: assert property (@(posedge clk) disable iff (rst)
		rx_fifo_pop |-> !(buffer_ram_output_enable || buffer_ram_write_strobe))
		else $error("pop during a ram access");

	// each ram write carries the byte taken at the fifo head
	chk_rx_byte: assert property (@(posedge clk) disable iff (rst)
		pop_now |=> mem_byte_out == $past(rx_fifo_data))
		else $error("ram byte not the fifo byte");

	// the write strobe only ever serves an rx burst
	chk_strobe_dir: assert property (@(posedge clk) disable iff (rst)
		buffer_ram_write_strobe |-> dir_q == lan_dma_pkg::dir_rx)
		else $error("write strobe on tx burst");

	// and the read strobe only ever serves a tx burst
	chk_read_dir: assert property (@(posedge clk) disable iff (rst)
		buffer_ram_output_enable |-> dir_q == lan_dma_pkg::dir_tx)
		else $error("read strobe on rx burst");

	// strobes appear only while a burst owns the engine
	chk_strobe_busy: assert property (@(posedge clk) disable iff (rst)
		(buffer_ram_output_enable || buffer_ram_write_strobe) |-> busy)
		else $error("strobe outside a burst");

	// a waiting access takes the first slot that comes
	chk_slot_next: assert property (@(posedge clk) disable iff (rst)
		(u_miu.st_q == lan_dma_pkg::mi_slot && slot_ok)
		|=> (buffer_ram_output_enable || buffer_ram_write_strobe))
		else $error("slot not used");

	// with slots free, strobe, done and the next setup follow back to back
	chk_byte_rate: assert property (@(posedge clk) disable iff (rst)
		(miu_start && slot_ok)
		|=> (buffer_ram_output_enable || buffer_ram_write_strobe) ##1 miu_done
		##1 (st_q == lan_dma_pkg::st_setup || st_q == lan_dma_pkg::st_idle))
		else $error("byte slower than three clocks");

	// second byte of a pair follows the first with no idle gap
	chk_pair_back: assert property (@(posedge clk) disable iff (rst)
		(st_q == lan_dma_pkg::st_wait && miu_done && !half_q)
		|=> st_q == lan_dma_pkg::st_setup)
		else $error("pair not back to back");

	// the buffer address steps by one after each access
	chk_addr_step: assert property (@(posedge clk) disable iff (rst)
		(st_q == lan_dma_pkg::st_wait && miu_done)
		|=> addr_q == $past(addr_q) + 16'h0001)
		else $error("address did not advance");

	// a tx byte reaches the fifo as the unit read it
	chk_tx_byte: assert property (@(posedge clk) disable iff (rst)
		tx_fifo_push |-> tx_fifo_data == $past(miu_rdata))
		else $error("tx byte differs from ram byte");

	// fifo pushes only happen on tx bursts
	chk_push_dir: assert property (@(posedge clk) disable iff (rst)
		tx_fifo_push |-> dir_q == lan_dma_pkg::dir_tx)
		else $error("push outside a tx burst");

	// register traffic leaves both data latches alone
	chk_reg_bypass: assert property (@(posedge clk) disable iff (rst)
		(reg_access && !busy) |=> ($stable(asm_lo_q) && $stable(out_byte_q)))
		else $error("register access hit a latch");

	// a narrow bus never drives or selects the high lane
	chk_narrow_lane: assert property (@(posedge clk) disable iff (rst)
		!wide_bus |-> (!mem_hi_lane && mem_wdata[15:8] == 8'h00))
		else $error("high lane used on narrow bus");

	// both directions, both bus widths and a contested start
	cov_rx_burst: cover property (@(posedge clk) burst_done && dir_q == lan_dma_pkg::dir_rx);
	cov_tx_burst: cover property (@(posedge clk) burst_done && dir_q == lan_dma_pkg::dir_tx);
	cov_both_req: cover property (@(posedge clk) rx_req && tx_req && !busy);
	cov_wide_write: cover property (@(posedge clk) wide_bus && buffer_ram_write_strobe);
	cov_narrow_read: cover property (@(posedge clk) !wide_bus && buffer_ram_output_enable);
endmodule

// ### dv/lan_buffer_partner.sv
// far side of the lan dma: buffer ram and the head of the rx fifo
// assumes one-cycle registered strobes and a byte address in mem_addr[7:0]
module lan_buffer_partner (
	input wire logic clk,
	input wire logic rst,
	input wire logic wide_bus,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic oe,
	input wire logic we,
	input wire logic rx_fifo_pop,
	output logic [15:0] mem_rdata,
	output logic [7:0] rx_fifo_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] ram [256];
	logic [15:0] word;
	logic [15:0] last_q = 16'h0000;
	logic [7:0] a;
	assign a = mem_addr[7:0];
	// wide bus returns the whole word, narrow puts junk on the high lane
	assign word = wide_bus ? {ram[a | 8'h01], ram[a & 8'hfe]} : {~ram[a], ram[a]};
	// released bus shows the inverse, so a stale value never matches
	assign mem_rdata = oe ? word : ~last_q;
	// ram starts with a known pattern for the tx reads
	always @(posedge clk) begin
		if (oe) last_q <= word;
		if (we) ram[a] <= (wide_bus && a[0]) ? mem_wdata[15:8] : mem_wdata[7:0];
	end
	initial for (int i = 0; i < 256; i++) ram[i] = 8'(i) ^ 8'h5a;
	// rx fifo head moves on every pop, so a missing pop repeats a byte
	always @(posedge clk or posedge rst) begin
		if (rst) rx_fifo_data <= 8'h00;
		else if (rx_fifo_pop) rx_fifo_data <= rx_fifo_data + 8'h01;
	end
endmodule

// ### dv/tb_lan_buffer_dma_controller.sv
// self-checking bench for the lan buffer dma controller
// assumes the partner model stands in for buffer ram and the rx fifo
module tb_lan_buffer_dma_controller;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst = 1'b1, wide_bus = 1'b0, slot_ok = 1'b1, tx_pending = 1'b0;
	logic reg_access = 1'b0, reg_write = 1'b0, last_stb = 1'b0;
	logic [7:0] reg_wdata = 8'h00, rx_exp = 8'h00, prev = 8'h00;
	logic [7:0] rx_fifo_data, tx_fifo_data, reg_rdata;
	logic [4:0] rx_fill = 5'h00, tx_fill = 5'h00;
	logic [15:0] rx_a = 16'h1230, tx_a = 16'hab80, mem_addr, mem_wdata, mem_rdata;
	logic rx_fifo_pop, tx_fifo_push, mem_hi_lane, oe, we, busy, burst_done;
	int n_errors = 0, comparisons = 0, n_wr = 0, n_rd = 0, n_push = 0;

	lan_buffer_dma_controller lan_buffer_dma_controller_i (.clk(clk), .rst(rst),
		.wide_bus(wide_bus), .slot_ok(slot_ok), .rx_fifo_level(rx_fill),
		.rx_fifo_data(rx_fifo_data), .rx_fifo_pop(rx_fifo_pop), .tx_fifo_level(tx_fill),
		.tx_fifo_data(tx_fifo_data), .tx_fifo_push(tx_fifo_push), .rx_addr(rx_a),
		.tx_addr(tx_a), .tx_pending(tx_pending), .reg_access(reg_access),
		.reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_hi_lane(mem_hi_lane), .buffer_ram_output_enable(oe),
		.buffer_ram_write_strobe(we), .busy(busy), .burst_done(burst_done));
	lan_buffer_partner lan_buffer_partner_i (.clk(clk), .rst(rst), .wide_bus(wide_bus),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .oe(oe), .we(we),
		.rx_fifo_pop(rx_fifo_pop), .mem_rdata(mem_rdata), .rx_fifo_data(rx_fifo_data));

	initial forever #50 clk = ~clk;

	// ----------------------------------------
	// helpers and strobe monitor
	// ----------------------------------------
	task automatic err(input string msg);
		n_errors++;
		$display("[ERR] %0t %s", $time, msg);
	endtask
	task automatic clear();
		n_wr = 0;
		n_rd = 0;
		n_push = 0;
	endtask
	// returns in the cycle of burst_done so requests can drop before the next edge
	task automatic wait_done(input int bound);
		int i;
		for (i = 0; i < bound && burst_done !== 1'b1; i++) @(negedge clk);
		comparisons++;
		if (i == bound) err("burst never finished");
	endtask
	// fifo fill follows the strobes, like the real fifos would
	always @(negedge clk) begin
		if (!rst) begin
			if (we || oe) begin
				comparisons += 3;
				if (last_stb) err("strobes in adjacent cycles");
				if (we && oe) err("both strobes at once");
				if (mem_hi_lane !== (wide_bus & mem_addr[0])) err("lane select");
			end
			if (we) begin
				comparisons += 2;
				if (mem_addr !== rx_a + 16'(n_wr)) err("rx address");
				if (wide_bus ? (mem_addr[0] ? mem_wdata !== {rx_exp, prev}
					: mem_wdata[7:0] !== rx_exp) : mem_wdata !== {8'h00, rx_exp})
					err("rx data");
				prev = rx_exp;
				rx_exp++;
				n_wr++;
				rx_fill--;
			end
			if (oe) begin
				comparisons++;
				if (mem_addr !== tx_a + 16'(n_rd)) err("tx address");
				n_rd++;
			end
			if (tx_fifo_push === 1'b1) begin
				comparisons++;
				if (tx_fifo_data !== ((tx_a[7:0] + 8'(n_push)) ^ 8'h5a)) err("tx data");
				n_push++;
				tx_fill++;
			end
			last_stb = we | oe;
		end
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_no_trigger();
		clear();
		rx_fill = 5'h07;
		tx_fill = 5'h09;
		tx_pending = 1'b1;
		repeat (30) @(negedge clk);
		comparisons++;
		if (busy !== 1'b0 || n_wr != 0 || n_rd != 0) err("burst below trigger");
		tx_pending = 1'b0;
		rx_fill = 5'h00;
	endtask
	task automatic t_rx(input logic w);
		clear();
		wide_bus = w;
		slot_ok = 1'b0;
		rx_fill = 5'h08;
		repeat (20) @(negedge clk);
		comparisons++;
		if (busy !== 1'b1 || n_wr != 0) err("access outside slot");
		slot_ok = 1'b1;
		wait_done(100);
		repeat (3) @(negedge clk);
		comparisons++;
		if (n_wr != 8 || rx_fill !== 5'h00) err("rx burst size");
	endtask
	task automatic t_tx();
		clear();
		tx_fill = 5'h08;
		tx_pending = 1'b1;
		wait_done(100);
		tx_pending = 1'b0;
		repeat (3) @(negedge clk);
		comparisons++;
		if (n_rd != 8 || n_push != 8) err("tx burst size");
	endtask
	// both pending: rx goes first and runs whole before tx
	task automatic t_prio();
		clear();
		wide_bus = 1'b0;
		rx_fill = 5'h08;
		tx_fill = 5'h00;
		tx_pending = 1'b1;
		wait_done(100);
		comparisons++;
		if (n_wr != 8 || n_rd != 0) err("rx not first or burst split");
		@(negedge clk);
		wait_done(100);
		tx_pending = 1'b0;
		repeat (3) @(negedge clk);
		comparisons++;
		if (n_rd != 8 || n_wr != 8) err("tx after rx");
	endtask
	task automatic t_reg();
		clear();
		reg_access = 1'b1;
		reg_write = 1'b0;
		reg_wdata = 8'hc3;
		@(negedge clk);
		reg_access = 1'b0;
		reg_write = 1'b0;
		repeat (2) @(negedge clk);
		comparisons++;
		if (reg_rdata !== 8'hc3 || n_wr != 0 || n_rd != 0) err("register path");
	endtask

	task automatic wrap_up();
		if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		t_no_trigger();
		t_rx(1'b0);
		t_rx(1'b1);
		t_tx();
		t_prio();
		t_reg();
		wrap_up();
	end
	// generous bound, the tests need well under a thousand cycles
	initial begin
		#500000;
		err("timeout");
		wrap_up();
	end
endmodule
